// ---- hdl/pba_arbiter.sv ----
`include "pba_consts.svh"
`default_nettype none

module pba_arbiter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [15:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        pci_clk,
  input  wire logic        frame_n,
  input  wire logic [3:0]  ext_req_n,
  input  wire logic        ext_gnt0_n_i,
  input  wire logic        ext_arb_strap,
  input  wire logic        ctrl_req,
  output logic             ctrl_gnt,
  output logic      [3:0]  ext_gnt_n_o,
  output logic      [3:0]  ext_gnt_n_oe_n,
  output logic             ext_req0_n_o,
  output logic             ext_req0_oe_n
);
  import pba_pkg::*;

  pba_state_t st_q;
  pba_state_t st_d;
  logic [7:0] pins_s;
  logic       s_pci;
  logic       s_frame_n;
  logic [3:0] s_req_n;
  logic       s_gnt0_n;
  logic       s_strap;
  logic [7:0] req_id;
  logic [7:0] slot_req;
  logic [7:0] elig;
  logic       found;
  pba_slot_t  win;
  logic [2:0] l1_nxt;
  logic [1:0] l2_nxt;
  logic       pci_rise;
  logic       run;
  logic       broken;
  logic       adv;
  logic       wr;
  logic       chk_on;

  // ========================================================================
  // helpers
  function automatic logic [2:0] slot_id(input logic [31:0] map, input pba_slot_t s);
    return map[{s, 2'b00} +: 3];
  endfunction

  function automatic logic [4:0] id_onehot(input logic [2:0] id);
    logic [7:0] t;
    t = 8'h01 << id;
    return t[4:0];
  endfunction

  function automatic logic addr_ok(input logic [15:0] a);
    return (a == `PBA_OFS_PORT_MAP) || (a == `PBA_OFS_CONFIG) ||
           (a == `PBA_OFS_STATUS)   || (a == `PBA_OFS_IRQ_EN) ||
           (a == `PBA_OFS_RECORD)   || (a == `PBA_OFS_CUR_REQ) ||
           (a == `PBA_OFS_CUR_GNT)  || (a == `PBA_OFS_STATE) ||
           (a == `PBA_OFS_IRQ_CLR);
  endfunction

  // ========================================================================
  // pin synchronisers
  pba_sync #(
    .W(8)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .async_in({pci_clk, frame_n, ext_req_n, ext_gnt0_n_i, ext_arb_strap}),
    .sync_out(pins_s)
  );

  assign s_pci     = pins_s[7];
  assign s_frame_n = pins_s[6];
  assign s_req_n   = pins_s[5:2];
  assign s_gnt0_n  = pins_s[1];
  assign s_strap   = pins_s[0];

  // ========================================================================
  // requests by requester id, then by slot through the port map
  // id 0 controller, ids 1..4 external lines 3..0, ids 5..7 reserved
  always_comb begin
    req_id = {3'b000, ~s_req_n[0] & ~st_q.ext_mode, ~s_req_n[1], ~s_req_n[2],
              ~s_req_n[3], ctrl_req};
    for (int s = 0; s < 8; s++) begin
      slot_req[s] = req_id[slot_id(st_q.port_map, pba_slot_t'(s))];
    end
  end

  assign chk_on = st_q.cfg[`PBA_CFG_CHK_BIT];
  // clearing the check bit lifts every exclusion at once
  assign elig   = slot_req & ~(st_q.record & {8{chk_on}});

  pba_rr u_rr (
    .elig  (elig),
    .l1_ptr(st_q.l1_ptr),
    .l2_ptr(st_q.l2_ptr),
    .found (found),
    .win   (win),
    .l1_nxt(l1_nxt),
    .l2_nxt(l2_nxt)
  );

  assign pci_rise = s_pci & ~st_q.pci_q;
  assign run      = st_q.strap_done & ~st_q.ext_mode & st_q.cfg[`PBA_CFG_ON_BIT];
  assign wr       = psel & penable & pwrite & ce;

  // ========================================================================
  // next state: bus slave first, then arbitration so hardware sets win
  always_comb begin
    st_d   = st_q;
    broken = 1'b0;
    adv    = 1'b0;
    // read data is captured in the setup cycle, so pready can stay high
    if (psel && !penable) begin
      case (paddr)
        `PBA_OFS_PORT_MAP: st_d.prdata = st_q.port_map;
        `PBA_OFS_CONFIG:   st_d.prdata = {28'h0000000, st_q.cfg};
        `PBA_OFS_STATUS:   st_d.prdata = {31'h00000000, st_q.status};
        `PBA_OFS_IRQ_EN:   st_d.prdata = {31'h00000000, st_q.irq_en};
        `PBA_OFS_RECORD:   st_d.prdata = {24'h000000, st_q.record};
        `PBA_OFS_CUR_REQ:  st_d.prdata = {24'h000000, slot_req};
        `PBA_OFS_CUR_GNT:  st_d.prdata = {27'h0000000, st_q.gnt};
        `PBA_OFS_STATE:    st_d.prdata = {14'h0000, st_q.strap_done, st_q.ext_mode,
                                          2'b00, st_q.l2_ptr, 1'b0, st_q.l1_ptr,
                                          2'b00, st_q.mode, 1'b0, st_q.owner};
        default:           st_d.prdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (paddr)
        `PBA_OFS_PORT_MAP: st_d.port_map = pwdata;
        `PBA_OFS_CONFIG:   st_d.cfg      = pwdata[3:0];
        `PBA_OFS_IRQ_EN:   st_d.irq_en   = pwdata[`PBA_ST_STUCK_BIT];
        `PBA_OFS_RECORD:   st_d.record   = st_q.record & ~pwdata[7:0];
        `PBA_OFS_IRQ_CLR:  st_d.status   = st_q.status & ~pwdata[`PBA_ST_STUCK_BIT];
        default:           st_d.status   = st_d.status;
      endcase
    end
    // boot strap is caught once the synchroniser has settled
    if (!st_q.strap_done) begin
      if (st_q.strap_wait == `PBA_STRAP_WAIT) begin
        st_d.strap_done = 1'b1;
        st_d.ext_mode   = s_strap;
      end else begin
        st_d.strap_wait = st_q.strap_wait + 2'd1;
      end
    end
    st_d.pci_q = s_pci;
    if (!run) begin
      st_d.mode  = PBA_OFF;
      st_d.armed = 1'b0;
    end else if (pci_rise) begin
      st_d.frame_q = s_frame_n;
      // idle-bus grant watchdog, counted in link clock periods
      if (st_q.armed && st_q.mode == PBA_OWN) begin
        if (!s_frame_n) begin
          st_d.armed = 1'b0;
        end else if (st_q.cnt == `PBA_FRAME_LIMIT - 5'd1) begin
          st_d.armed = 1'b0;
          if (chk_on) begin
            broken                = 1'b1;
            st_d.record[st_q.owner] = 1'b1;
            st_d.status           = 1'b1;
          end
        end else begin
          st_d.cnt = st_q.cnt + 5'd1;
        end
      end
      // re-arbitrate once the owner starts, drops out or is found broken
      case (st_q.mode)
        PBA_OWN: adv = ~elig[st_q.owner] | broken | (st_q.frame_q & ~s_frame_n);
        default: adv = 1'b1;
      endcase
      if (adv) begin
        if (found) begin
          st_d.owner  = win;
          st_d.mode   = PBA_OWN;
          st_d.l1_ptr = l1_nxt;
          st_d.l2_ptr = l2_nxt;
          st_d.armed  = s_frame_n;
          st_d.cnt    = 5'd0;
        end else begin
          st_d.mode  = PBA_PARK;
          st_d.armed = 1'b0;
          if (st_q.cfg[`PBA_CFG_FIX_BIT]) begin
            st_d.owner = 3'd0;
          end else begin
            st_d.owner = st_q.owner;
          end
        end
      end
    end
    // registered pin and interrupt outputs
    st_d.gnt      = (st_d.mode == PBA_OFF) ? 5'b00000
                    : id_onehot(slot_id(st_d.port_map, st_d.owner));
    st_d.ctrl_gnt = st_d.ext_mode ? ~s_gnt0_n : st_d.gnt[0];
    st_d.req0     = st_d.ext_mode & ctrl_req;
    st_d.irq      = st_d.status & st_d.irq_en;
  end

  // ========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= '0;
      st_q.port_map <= `PBA_RST_PORT_MAP;
      st_q.cfg      <= `PBA_RST_CONFIG;
      st_q.pci_q    <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // outputs
  assign prdata         = st_q.prdata;
  assign pready         = ce; // a frozen block holds the access phase
  assign pslverr        = psel & penable & ~addr_ok(paddr);
  assign irq            = st_q.irq;
  assign ctrl_gnt       = st_q.ctrl_gnt;
  assign ext_gnt_n_o    = ~{st_q.gnt[1], st_q.gnt[2], st_q.gnt[3], st_q.gnt[4]};
  assign ext_gnt_n_oe_n = {3'b000, st_q.ext_mode};
  assign ext_req0_n_o   = ~st_q.req0;
  assign ext_req0_oe_n  = ~st_q.ext_mode;

  // ========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_one_grant: assert property ($onehot0(st_q.gnt))
    else $error("more than one grant active");
  chk_fixed_park: assert property (ce && run && pci_rise && adv && !found &&
                                   st_q.cfg[`PBA_CFG_FIX_BIT]
                                   |=> st_q.owner == 3'd0 && st_q.mode == PBA_PARK)
    else $error("fixed park not on port A");
  chk_last_park: assert property (ce && run && pci_rise && adv && !found &&
                                  !st_q.cfg[`PBA_CFG_FIX_BIT]
                                  |=> st_q.owner == $past(st_q.owner))
    else $error("park moved off last owner");
  chk_off_quiet: assert property (ce && !st_q.cfg[`PBA_CFG_ON_BIT]
                                  |=> st_q.gnt == 5'b00000)
    else $error("grant while arbiter disabled");
  chk_watch_bound: assert property (st_q.armed |-> st_q.cnt < `PBA_FRAME_LIMIT)
    else $error("watchdog count overran");
  chk_broken_flag: assert property (ce && run && pci_rise && st_q.armed && chk_on &&
                                    st_q.mode == PBA_OWN && s_frame_n &&
                                    st_q.cnt == `PBA_FRAME_LIMIT - 5'd1
                                    |=> st_q.status && st_q.record[$past(st_q.owner)])
    else $error("broken master not recorded");
  chk_check_gate: assert property (!chk_on |=> !$rose(st_q.status))
    else $error("status set with checking off");
  chk_l2_order: assert property (ce && run && pci_rise && adv && found && win[2]
                                 |=> st_q.l2_ptr == $past(win[1:0]) &&
                                     st_q.l1_ptr == 3'd4)
    else $error("group pointer not advanced");
  chk_ext_pins: assert property (st_q.ext_mode |-> !ext_req0_oe_n && ext_gnt_n_oe_n[0]
                                 && st_q.gnt == 5'b00000)
    else $error("pair 0 direction wrong in external mode");
  chk_irq_level: assert property (irq |-> $past(st_q.irq_en) || $past(ce) == 1'b0 ||
                                  st_q.irq_en)
    else $error("interrupt without enable");
  // only a record write or a detection on a link edge may touch the record
  chk_record_hold: assert property (ce && !(wr && paddr == `PBA_OFS_RECORD) && !pci_rise
                                    |=> st_q.record == $past(st_q.record))
    else $error("broken record changed on its own");
  chk_ext_req: assert property (ce && st_q.ext_mode
                                |=> ext_req0_n_o == !$past(ctrl_req))
    else $error("request out does not follow the controller");

endmodule

`default_nettype wire

// ---- common/pba_consts.svh ----
`ifndef PBA_CONSTS_SVH
`define PBA_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define PBA_OFS_PORT_MAP    16'hd100
`define PBA_OFS_CONFIG      16'hd104
`define PBA_OFS_STATUS      16'hd108
`define PBA_OFS_IRQ_EN      16'hd10c
`define PBA_OFS_RECORD      16'hd110
`define PBA_OFS_CUR_REQ     16'hd114
`define PBA_OFS_CUR_GNT     16'hd118
`define PBA_OFS_STATE       16'hd11c
`define PBA_OFS_IRQ_CLR     16'hd124

// ==========================================================================
// field positions
`define PBA_CFG_ON_BIT      0
`define PBA_CFG_CHK_BIT     1
`define PBA_CFG_FIX_BIT     3
`define PBA_ST_STUCK_BIT    0

// ==========================================================================
// reset values
`define PBA_RST_PORT_MAP    32'h76543210
`define PBA_RST_CONFIG      4'h0

// ==========================================================================
// timing counts, in link clock periods and in pclk cycles
`define PBA_FRAME_LIMIT     5'd16
`define PBA_STRAP_WAIT      2'd2

`endif

// ---- common/pba_pkg.sv ----
`default_nettype none

package pba_pkg;

  // ========================================================================
  // slots 0..3 are the first-level ports, 4..7 the shared second-level group
  typedef logic [2:0] pba_slot_t;

  typedef enum logic [1:0] {
    PBA_OFF  = 2'b00,
    PBA_PARK = 2'b01,
    PBA_OWN  = 2'b10
  } pba_mode_t;

  typedef struct packed {
    logic [31:0] port_map;
    logic [3:0]  cfg;
    logic        irq_en;
    logic        status;
    logic [7:0]  record;
    pba_mode_t   mode;
    pba_slot_t   owner;
    logic [2:0]  l1_ptr;
    logic [1:0]  l2_ptr;
    logic [4:0]  cnt;
    logic        armed;
    logic        frame_q;
    logic        pci_q;
    logic [1:0]  strap_wait;
    logic        strap_done;
    logic        ext_mode;
    logic [4:0]  gnt;
    logic        ctrl_gnt;
    logic        req0;
    logic        irq;
    logic [31:0] prdata;
  } pba_state_t;

endpackage

`default_nettype wire

// ---- hdl/pba_sync.sv ----
`default_nettype none

// ==========================================================================
// two-stage synchroniser for pins from outside the pclk domain
module pba_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import pba_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pba_sync_st_t;

  pba_sync_st_t st_q;
  pba_sync_st_t st_d;

  // first stage feeds only the second
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule

`default_nettype wire

// ---- hdl/pba_rr.sv ----
`default_nettype none

// ==========================================================================
// two-level round-robin pick: positions 0..3 first level, 4 = group slot
module pba_rr (
  input  wire logic [7:0] elig,
  input  wire logic [2:0] l1_ptr,
  input  wire logic [1:0] l2_ptr,
  output logic            found,
  output logic      [2:0] win,
  output logic      [2:0] l1_nxt,
  output logic      [1:0] l2_nxt
);
  import pba_pkg::*;

  logic [1:0] l2_pick;
  logic       l2_any;
  logic [2:0] pos;
  logic [1:0] idx;

  function automatic logic [2:0] wrap5(input logic [2:0] p, input int step);
    int s;
    s = int'(p) + step;
    if (s >= 5) begin
      s = s - 5;
    end
    return s[2:0];
  endfunction

  // searching from the far end leaves the nearest candidate last
  always_comb begin
    found   = 1'b0;
    win     = '0;
    l1_nxt  = l1_ptr;
    l2_nxt  = l2_ptr;
    l2_pick = l2_ptr;
    pos     = '0;
    idx     = '0;
    l2_any  = |elig[7:4];
    for (int i = 4; i >= 1; i--) begin
      idx = l2_ptr + i[1:0];
      if (elig[3'd4 + {1'b0, idx}]) begin
        l2_pick = idx;
      end
    end
    for (int i = 5; i >= 1; i--) begin
      pos = wrap5(l1_ptr, i);
      if ((pos < 3'd4) ? elig[pos] : l2_any) begin
        found  = 1'b1;
        l1_nxt = pos;
      end
    end
    if (found) begin
      win = (l1_nxt == 3'd4) ? (3'd4 + {1'b0, l2_pick}) : l1_nxt;
      if (l1_nxt == 3'd4) begin
        l2_nxt = l2_pick;
      end
    end
  end

endmodule

`default_nettype wire

// ---- sim/pba_master_model.sv ----
`default_nettype none

// ==========================================================================
// far-side bus masters, indexed by requester id (0 is the controller)
module pba_master_model (
  input  wire logic       pci_clk,
  input  wire logic [4:0] gnt,
  input  wire logic [4:0] want,
  input  wire logic [4:0] lazy,
  output logic      [4:0] req,
  output logic            frame_n
);
  timeunit 1ns;
  timeprecision 1ps;

  int busy = -1;
  int cnt  = 0;

  initial begin
    req = 5'h00;
    frame_n = 1'h1;
  end

  // an owner drops its request while it runs; a lazy master never starts,
  // which is the only misbehaviour the bench commands
  always @(posedge pci_clk) begin
    for (int i = 0; i < 5; i++) begin
      req[i] <= want[i] && (i != busy);
    end
    if (busy >= 0) begin
      cnt = cnt - 1;
      if (cnt == 0) begin
        frame_n <= 1'h1;  // released line rests on its pull-up
        busy = -1;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (busy < 0 && gnt[i] && req[i] && !lazy[i] && frame_n) begin
          frame_n <= 1'h0;
          busy = i;
          cnt = 2;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- sim/pci_two_level_bus_arbiter_tb.sv ----
`include "pba_consts.svh"
`default_nettype none

module pci_two_level_bus_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [15:0] a;
    logic        w;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } pba_row_t;

  logic        pclk    = 1'h0;
  logic        presetn = 1'h0;
  logic        pci_clk = 1'h0;
  logic [15:0] paddr   = 16'h0000;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        ctrl_gnt;
  logic        req0_oe_n;
  logic        ce      = 1'h1;
  logic        strap   = 1'h0;
  logic        gnt0_n  = 1'h1;
  logic        req0_n;
  logic [3:0]  gnt_oe_n;
  logic        frame_n;
  logic [3:0]  gnt_n;
  logic [4:0]  req;
  logic [4:0]  g;
  logic [4:0]  want    = 5'h00;
  logic [4:0]  lazy    = 5'h00;
  logic [2:0]  gid;
  logic [2:0]  last_id = 3'h7;
  logic [2:0]  glog[$];
  logic [31:0] rd;
  logic        er;
  int          failures = 0;
  int          n_tests  = 0;
  int          n;
  int          f;

  // register walk: reset values, round trips, refused and ignored accesses
  pba_row_t rows[11] = '{
    '{`PBA_OFS_PORT_MAP, 1'h0, 32'h0, 32'h76543210, 1'h0},
    '{`PBA_OFS_CONFIG, 1'h0, 32'h0, 32'h0, 1'h0},
    '{`PBA_OFS_STATUS, 1'h0, 32'h0, 32'h0, 1'h0},
    '{`PBA_OFS_RECORD, 1'h0, 32'h0, 32'h0, 1'h0},
    '{`PBA_OFS_PORT_MAP, 1'h1, 32'h73546210, 32'h0, 1'h0},
    '{`PBA_OFS_PORT_MAP, 1'h0, 32'h0, 32'h73546210, 1'h0},
    '{`PBA_OFS_CONFIG, 1'h1, 32'hb, 32'h0, 1'h0},
    '{`PBA_OFS_CONFIG, 1'h0, 32'h0, 32'hb, 1'h0},
    '{`PBA_OFS_STATUS, 1'h1, 32'h1, 32'h0, 1'h0},
    '{`PBA_OFS_STATUS, 1'h0, 32'h0, 32'h0, 1'h0},
    '{16'hd120, 1'h0, 32'h0, 32'h0, 1'h1}
  };

  always #2 pclk = ~pclk;
  always #32 pci_clk = ~pci_clk;

  pba_arbiter pba_arbiter_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .pci_clk(pci_clk),
    .frame_n(frame_n), .ext_req_n(~{req[1], req[2], req[3], req[4]}),
    .ext_gnt0_n_i(gnt0_n), .ext_arb_strap(strap), .ctrl_req(req[0]),
    .ctrl_gnt(ctrl_gnt), .ext_gnt_n_o(gnt_n), .ext_gnt_n_oe_n(gnt_oe_n),
    .ext_req0_n_o(req0_n), .ext_req0_oe_n(req0_oe_n)
  );

  pba_master_model pba_master_model_inst (
    .pci_clk(pci_clk), .gnt(g), .want(want), .lazy(lazy), .req(req),
    .frame_n(frame_n)
  );

  // grants seen per requester id; 7 means nobody holds the bus
  assign g = {~gnt_n[0], ~gnt_n[1], ~gnt_n[2], ~gnt_n[3], ctrl_gnt};
  always_comb begin
    gid = 3'h7;
    for (int i = 0; i < 5; i++) begin
      if (g[i] === 1'h1) gid = 3'(i);
    end
  end

  // log only changes of owner, so parking does not pad the sequence
  always @(posedge pclk) begin
    if (gid !== last_id) begin
      last_id <= gid;
      if (gid !== 3'h7) glog.push_back(gid);
    end
  end

  // ========================================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_id(input string nm, input logic [2:0] exp, input logic [2:0] got);
    chk(nm, {29'h0, exp}, {29'h0, got});
  endtask

  // one transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic pci(input int c);
    repeat (c) @(posedge pci_clk);
    @(posedge pclk);
  endtask

  task automatic wait_gnt(input logic [2:0] id);
    int k;
    k = 0;
    while (gid !== id && k < 4000) begin
      @(posedge pclk);
      k++;
    end
    chk_id("grant", id, gid);
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a third of this span
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  // ========================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    want <= 5'h04;
    pci(20);
    chk_id("grant while off", 3'h7, gid);
    chk("req0 enable", 32'h1, {31'h0, req0_oe_n});
    want <= 5'h00;
    pci(4);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, er});
      if (!rows[i].w) chk("rdata", rows[i].q, rd);
    end
    pci(4);
    chk_id("fixed park", 3'h0, gid);
    // controller alone on level one, the four lines on level two
    apb(`PBA_OFS_PORT_MAP, 1'h1, 32'h43217650);
    apb(`PBA_OFS_CONFIG, 1'h1, 32'h1);
    glog.delete();
    want <= 5'h1f;
    n = 0;
    while (glog.size() < 12 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    // a rotation that stalls counts against the run
    if (n >= 20000) failures++;
    f = 1;
    while (f < 4 && glog[f] != 3'h0) f++;
    for (int j = 0; j < 4; j++) begin
      chk_id("level one", 3'h0, glog[f + 2 * j]);
      chk_id("level two", 3'((glog[f + 1] - 1 + j) % 4 + 1), glog[f + 1 + 2 * j]);
    end
    // B owns, then A and W ask together: W must come first
    want <= 5'h00;
    apb(`PBA_OFS_PORT_MAP, 1'h1, 32'h76543210);
    pci(8);
    want <= 5'h02;
    wait_gnt(3'h1);
    pci(2);
    want <= 5'h00;
    pci(6);
    glog.delete();
    want <= 5'h11;
    pci(12);
    chk_id("after B", 3'h4, glog[0]);
    chk_id("then", 3'h0, glog[1]);
    want <= 5'h10;
    pci(10);
    want <= 5'h00;
    pci(6);
    chk_id("last park", 3'h4, gid);
    apb(`PBA_OFS_CONFIG, 1'h1, 32'h9);
    pci(4);
    chk_id("fixed park", 3'h0, gid);
    // stuck master on slot B with checking on, interrupt masked first
    apb(`PBA_OFS_CONFIG, 1'h1, 32'h3);
    lazy <= 5'h02;
    want <= 5'h06;
    wait_gnt(3'h1);
    pci(24);
    apb(`PBA_OFS_STATUS, 1'h0, 32'h0);
    chk("status", 32'h1, rd);
    apb(`PBA_OFS_RECORD, 1'h0, 32'h0);
    chk("record", 32'h2, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(`PBA_OFS_IRQ_EN, 1'h1, 32'h1);
    pci(1);
    chk("irq", 32'h1, {31'h0, irq});
    glog.delete();
    pci(40);
    n = 0;
    foreach (glog[k]) n += (glog[k] == 3'h1);
    chk("stuck regrants", 32'h0, n);
    apb(`PBA_OFS_RECORD, 1'h0, 32'h0);
    chk("record held", 32'h2, rd);
    want <= 5'h00;
    lazy <= 5'h00;
    apb(`PBA_OFS_RECORD, 1'h1, 32'h2);
    apb(`PBA_OFS_IRQ_CLR, 1'h1, 32'h1);
    pci(2);
    apb(`PBA_OFS_STATUS, 1'h0, 32'h0);
    chk("status clear", 32'h0, rd);
    apb(`PBA_OFS_RECORD, 1'h0, 32'h0);
    chk("record clear", 32'h0, rd);
    chk("irq clear", 32'h0, {31'h0, irq});
    // same fault with checking off goes unnoticed
    apb(`PBA_OFS_CONFIG, 1'h1, 32'h1);
    lazy <= 5'h08;
    want <= 5'h08;
    wait_gnt(3'h3);
    pci(24);
    apb(`PBA_OFS_STATUS, 1'h0, 32'h0);
    chk("status off", 32'h0, rd);
    chk_id("still owner", 3'h3, gid);
    // clock enable low: the owner drops out but nothing may move
    ce <= 1'h0;
    want <= 5'h04;
    pci(6);
    chk_id("frozen owner", 3'h3, gid);
    ce <= 1'h1;
    pci(8);
    chk_id("thawed", 3'h2, gid);
    // second reset with the strap high: pair 0 turns round
    want <= 5'h00;
    strap <= 1'h1;
    presetn <= 1'h0;
    @(posedge pclk);
    chk("grants in reset", 32'h0, {27'h0, g});
    chk("irq in reset", 32'h0, {31'h0, irq});
    @(posedge pclk);
    presetn <= 1'h1;
    apb(`PBA_OFS_CONFIG, 1'h1, 32'h1);
    want <= 5'h11;
    pci(4);
    chk("req0 driven", 32'h0, {31'h0, req0_oe_n});
    chk("grant enables", 32'h1, {28'h0, gnt_oe_n});
    chk("req0 pin", 32'h0, {31'h0, req0_n});
    chk("no grants", 32'hf, {28'h0, gnt_n});
    chk("ctrl gnt idle", 32'h0, {31'h0, ctrl_gnt});
    gnt0_n <= 1'h0;
    pci(2);
    chk("ctrl gnt in", 32'h1, {31'h0, ctrl_gnt});
    report_and_stop();
  end
endmodule

`default_nettype wire
